// File: ots_pkg.sv
// package: register map, field layout, reset values and timing for trim control
//
// Contract
// [R1] regulator trim driven out; FF highest, 00 lowest
// [R2] reset restores coarse 01, fine 8E defaults
// [R3] software reloads calibrated trims after each reset
// [R4] oscillator enabled except in stop state
// [R5] oscillator on/off causes no clock glitches
// [R6] update field zero: fine value passes unchanged
// [R7] amplitude select: 32, 16, 8, 4; code decodes select 0..3 as 4, 8, 16, 32
// [R8] coarse range low bits drive oscillator band
// [R9] larger fine code gives lower frequency
// [R10] active spread: fine value plus sweeping offset
// [R11] update field sets cycles between updates
// [R12] full sweep lasts 4*interval*(2*amp+1) cycles
// [R13] modulated fine code saturates at 0, 255
// [R14] software keeps fine within amp..256-amp
// [R15] software calibrates 16MHz by binary search
// [R16] offset moves one step, triangular pattern
package ots_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OTS_ADDR_REG_TRIM   = 16'hA000;
  localparam logic [15:0] OTS_ADDR_COARSE_SS  = 16'hA001;
  localparam logic [15:0] OTS_ADDR_FINE_TRIM  = 16'hA002;
  localparam logic [15:0] OTS_ADDR_STATUS     = 16'hA003;

  // ---------------------------------------------------------------
  // field positions of the coarse and spread register
  // ---------------------------------------------------------------
  localparam int OTS_COARSE_LSB   = 0;
  localparam int OTS_AMP_LSB      = 2;
  localparam int OTS_INTERVAL_LSB = 4;

  // status register bits above the effective fine code
  localparam int OTS_STAT_OSC_EN_BIT  = 8;
  localparam int OTS_STAT_CLK_ON_BIT  = 9;
  localparam int OTS_STAT_SPREAD_BIT  = 10;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OTS_RST_REG_TRIM  = 8'hFF;
  localparam logic [7:0] OTS_RST_COARSE_SS = 8'h01;
  localparam logic [7:0] OTS_RST_FINE_TRIM = 8'h8E;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int OTS_CLK_PERIOD_PS  = 5000;
  // oscillator settles within this many ref_clk_i cycles
  localparam int OTS_OSC_SETTLE_CYC = 10;
  // gate closes this long before the oscillator stops
  localparam int OTS_GATE_LEAD_NS   = 10;
  localparam int OTS_GATE_LEAD_CYC  =
    ((OTS_GATE_LEAD_NS * 1000 + OTS_CLK_PERIOD_PS - 1) / OTS_CLK_PERIOD_PS < 1) ? 1 :
    (OTS_GATE_LEAD_NS * 1000 + OTS_CLK_PERIOD_PS - 1) / OTS_CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] interval;
    logic [1:0] amp_sel;
    logic [1:0] coarse_range;
  } ots_coarse_ss_t;

  typedef enum {
    OTS_ST_RUN,
    OTS_ST_GATE_OFF,
    OTS_ST_OSC_OFF,
    OTS_ST_WAKE
  } ots_state_t;

endpackage : ots_pkg

// File: ots_sweep.sv
// module: triangular spread modulator with saturating fine code output
module ots_sweep
  import ots_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  wire logic           sys_rst_i,
  input  wire ots_coarse_ss_t cfg_i,
  input  wire logic [7:0]     fine_value_i,
  output logic [7:0]          effective_fine_out_o,
  output logic                spread_active_o
);

  // ---------------------------------------------------------------
  // amplitude decode
  // ---------------------------------------------------------------
  wire logic       spread_on = (cfg_i.interval != 4'h0);
  // [R7] amplitude select
  wire logic [6:0] amp       = 7'(7'h04 << cfg_i.amp_sel);

  logic [3:0]        tick_cnt_reg;
  logic              dwell_reg;
  logic              dir_up_reg;
  logic signed [6:0] offset_reg;

  // [R11] update every interval cycles
  wire logic tick = spread_on && (tick_cnt_reg == cfg_i.interval - 4'h1);
  // [R12] each step held two updates
  wire logic step = tick && dwell_reg;

  wire logic signed [6:0] amp_s  = signed'(amp);
  wire logic at_top = (offset_reg >= amp_s);
  wire logic at_bot = (offset_reg <= -amp_s);

  // [R10] fine value plus offset
  wire logic signed [9:0] sum = signed'({2'b00, fine_value_i}) + 10'(offset_reg);
  // [R13] saturate at both bounds
  wire logic [7:0] sat = (sum < 10'sd0)   ? 8'h00 :
                         (sum > 10'sd255) ? 8'hFF : sum[7:0];

  // ---------------------------------------------------------------
  // sweep state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !spread_on) begin
      tick_cnt_reg <= 4'h0;
      dwell_reg    <= 1'b0;
      dir_up_reg   <= 1'b1;
      offset_reg   <= 7'sd0;
    end else begin
      tick_cnt_reg <= tick ? 4'h0 : tick_cnt_reg + 4'h1;
      if (tick) begin
        dwell_reg <= !dwell_reg;
      end
      // [R16] one step, triangular
      // [R12] peak held one step
      if (step) begin
        if (dir_up_reg) begin
          if (at_top) begin
            dir_up_reg <= 1'b0;
          end else begin
            offset_reg <= offset_reg + 7'sd1;
          end
        end else begin
          if (at_bot) begin
            dir_up_reg <= 1'b1;
          end else begin
            offset_reg <= offset_reg - 7'sd1;
          end
        end
      end
    end
  end

  // [R6] disabled: fine value unchanged
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      effective_fine_out_o <= OTS_RST_FINE_TRIM;
      spread_active_o      <= 1'b0;
    end else begin
      effective_fine_out_o <= spread_on ? sat : fine_value_i;
      spread_active_o      <= spread_on;
    end
  end

endmodule : ots_sweep

// File: ots_trim_ctrl.sv
// module: trim register file, oscillator enable sequencing and spread modulator
module ots_trim_ctrl
  import ots_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  input  wire logic        stop_mode_i,
  output logic [7:0]       regulator_level_o,
  output logic [1:0]       coarse_range_o,
  output logic [7:0]       effective_fine_out_o,
  output logic             osc_enable_o,
  output logic             sys_clk_gate_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic sel_reg_trim = (addr_i == OTS_ADDR_REG_TRIM);
  wire logic sel_coarse   = (addr_i == OTS_ADDR_COARSE_SS);
  wire logic sel_fine     = (addr_i == OTS_ADDR_FINE_TRIM);
  wire logic sel_status   = (addr_i == OTS_ADDR_STATUS);

  wire logic wr_reg_trim  = wr_i && sel_reg_trim;
  wire logic wr_coarse    = wr_i && sel_coarse;
  wire logic wr_fine      = wr_i && sel_fine;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [7:0]     regulator_level_trim_reg;
  ots_coarse_ss_t osc_coarse_and_spread_reg;
  logic [7:0]     osc_fine_trim_reg;

  // [R2] defaults on every reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      regulator_level_trim_reg  <= OTS_RST_REG_TRIM;
      osc_coarse_and_spread_reg <= OTS_RST_COARSE_SS;
      osc_fine_trim_reg         <= OTS_RST_FINE_TRIM;
    end else begin
      if (wr_reg_trim) begin
        regulator_level_trim_reg <= wdata_i;
      end
      if (wr_coarse) begin
        osc_coarse_and_spread_reg <= wdata_i;
      end
      if (wr_fine) begin
        osc_fine_trim_reg <= wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // analog control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      regulator_level_o <= OTS_RST_REG_TRIM;
      coarse_range_o    <= OTS_RST_COARSE_SS[1:0];
    end else begin
      // [R1] regulator code passed as written
      regulator_level_o <= regulator_level_trim_reg;
      // [R8] coarse band straight to oscillator
      coarse_range_o    <= osc_coarse_and_spread_reg.coarse_range;
    end
  end

  // ---------------------------------------------------------------
  // spread modulator
  // ---------------------------------------------------------------
  logic spread_active;

  // [R9] fine code drives oscillator, higher is slower
  ots_sweep u_sweep (
    .ref_clk_i            (ref_clk_i),
    .sys_rst_i            (sys_rst_i),
    .cfg_i                (osc_coarse_and_spread_reg),
    .fine_value_i         (osc_fine_trim_reg),
    .effective_fine_out_o (effective_fine_out_o),
    .spread_active_o      (spread_active)
  );

  // ---------------------------------------------------------------
  // stop request synchroniser
  // ---------------------------------------------------------------
  logic stop_s1_reg;
  logic stop_s2_reg;
  logic stop_s3_reg;
  logic stop_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      stop_s3_reg <= 1'b0;
      stop_reg    <= 1'b0;
    end else begin
      stop_s1_reg <= stop_mode_i;
      stop_s2_reg <= stop_s1_reg;
      stop_s3_reg <= stop_s2_reg;
      if (stop_s2_reg == stop_s3_reg) begin
        stop_reg <= stop_s3_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator enable sequencer
  // ---------------------------------------------------------------
  ots_state_t state_reg;
  ots_state_t state_next;
  logic [4:0] wait_cnt_reg;
  logic [4:0] wait_cnt_next;

  localparam logic [4:0] LEAD_LAST   = 5'(OTS_GATE_LEAD_CYC - 1);
  localparam logic [4:0] SETTLE_LAST = 5'(OTS_OSC_SETTLE_CYC - 1);

  wire logic wait_done = (state_reg == OTS_ST_GATE_OFF) ? (wait_cnt_reg == LEAD_LAST) :
                                                          (wait_cnt_reg == SETTLE_LAST);

  always_comb begin
    state_next    = state_reg;
    wait_cnt_next = 5'h00;
    case (state_reg)
      OTS_ST_RUN: begin
        // [R4] leave run only for stop
        if (stop_reg) begin
          state_next = OTS_ST_GATE_OFF;
        end
      end
      OTS_ST_GATE_OFF: begin
        // [R5] gate closed before oscillator stops
        if (wait_done) begin
          state_next = OTS_ST_OSC_OFF;
        end else begin
          wait_cnt_next = wait_cnt_reg + 5'h01;
        end
      end
      OTS_ST_OSC_OFF: begin
        if (!stop_reg) begin
          state_next = OTS_ST_WAKE;
        end
      end
      OTS_ST_WAKE: begin
        // [R5] gate opens only once stable
        if (wait_done) begin
          state_next = OTS_ST_RUN;
        end else begin
          wait_cnt_next = wait_cnt_reg + 5'h01;
        end
      end
      default: begin
        state_next = OTS_ST_RUN;
      end
    endcase
  end

  wire logic osc_en_next  = (state_next != OTS_ST_OSC_OFF);
  wire logic clk_on_next  = (state_next == OTS_ST_RUN);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg      <= OTS_ST_RUN;
      wait_cnt_reg   <= 5'h00;
      osc_enable_o   <= 1'b1;
      sys_clk_gate_o <= 1'b1;
    end else begin
      state_reg      <= state_next;
      wait_cnt_reg   <= wait_cnt_next;
      // [R4] oscillator off only in stop
      osc_enable_o   <= osc_en_next;
      sys_clk_gate_o <= clk_on_next;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire logic [15:0] status_word = {5'h00,
                                   spread_active,
                                   sys_clk_gate_o,
                                   osc_enable_o,
                                   effective_fine_out_o};

  // fine trim is write-only and reads as zero
  wire logic [15:0] rd_mux = sel_reg_trim ? {8'h00, regulator_level_trim_reg} :
                             sel_coarse   ? {8'h00, osc_coarse_and_spread_reg} :
                             sel_status   ? status_word : 16'h0000;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 16'h0000;
    end
  end

endmodule : ots_trim_ctrl

// File: ots_trim_ctrl_checker.sv
// checker: bus, stop sequencing and sweep properties
module ots_trim_ctrl_checker
  import ots_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        stop_mode_i,
  input wire logic [7:0]  regulator_level_o,
  input wire logic [1:0]  coarse_range_o,
  input wire logic [7:0]  effective_fine_out_o,
  input wire logic        osc_enable_o,
  input wire logic        sys_clk_gate_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ------------------------------
  // shadow of fine and spread
  // ------------------------------
  logic [7:0] fine_reg;
  logic [7:0] cfg_reg;
  logic [1:0] quiet_reg;
  wire [7:0] amp_w  = 8'h04 << cfg_reg[3:2];
  wire [8:0] hi_w   = {1'b0, fine_reg} + {1'b0, amp_w};
  wire [8:0] lo_w   = {1'b0, fine_reg} - {1'b0, amp_w};
  wire [7:0] top_w  = hi_w[8] ? 8'hFF : hi_w[7:0];
  wire [7:0] bot_w  = lo_w[8] ? 8'h00 : lo_w[7:0];
  wire       fw_w   = wr_i && addr_i == OTS_ADDR_FINE_TRIM;
  wire       cw_w   = wr_i && addr_i == OTS_ADDR_COARSE_SS;
  wire       calm_w = quiet_reg == 2'h3;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fine_reg  <= OTS_RST_FINE_TRIM;
      cfg_reg   <= OTS_RST_COARSE_SS;
      quiet_reg <= 2'h0;
    end else begin
      if (fw_w) fine_reg <= wdata_i;
      if (cw_w) cfg_reg <= wdata_i;
      quiet_reg <= (fw_w || cw_w) ? 2'h0 : (calm_w ? 2'h3 : quiet_reg + 2'h1);
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  a_reset_defaults: assert property ($fell(sys_rst_i) |-> regulator_level_o == 8'hFF &&
    coarse_range_o == 2'h1 && effective_fine_out_o == 8'h8E) else $error("bad reset values");
  a_reg_readback: assert property (rd_i && addr_i == OTS_ADDR_REG_TRIM |=>
    rdata_o == {8'h00, regulator_level_o}) else $error("trim readback differs");
  a_idle_rdata: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("rdata not zero");
  a_gate_needs_osc: assert property (!osc_enable_o |-> !sys_clk_gate_o) else $error("gate open");
  a_gate_leads_off: assert property ($fell(osc_enable_o) |-> !$past(sys_clk_gate_o))
    else $error("gate closed late");
  a_wake_gate_hold: assert property ($rose(osc_enable_o) |-> !sys_clk_gate_o [*8])
    else $error("gate opened early");
  a_osc_runs: assert property (!stop_mode_i [*8] |-> osc_enable_o) else $error("osc off");
  a_fixed_pass: assert property (calm_w && cfg_reg[7:4] == 4'h0 |->
    effective_fine_out_o == fine_reg) else $error("fine code altered");
  a_spread_bound: assert property (calm_w && cfg_reg[7:4] != 4'h0 |->
    effective_fine_out_o <= top_w && effective_fine_out_o >= bot_w) else $error("out of band");
  a_step_one: assert property (calm_w && $past(calm_w) |->
    effective_fine_out_o - $past(effective_fine_out_o) inside {8'h00, 8'h01, 8'hFF})
    else $error("offset jumped");
endmodule : ots_trim_ctrl_checker

bind ots_trim_ctrl ots_trim_ctrl_checker u_chk (.*);

// File: testbench.sv
// testbench: registers, sweep and stop sequencing
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
  import ots_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        stop = 1'b0;
  logic [15:0] rdata;
  logic [7:0]  lvl;
  logic [1:0]  crs;
  logic [7:0]  eff;
  logic        osc;
  logic        gate;
  logic [15:0] q;
  logic [7:0]  mn, mx, prev;
  int          err_total, num_checks, cyc, i, j, n, pk;
  int          tp[2];
  logic [15:0] t_a[6] = '{16'hA000, 16'hA000, 16'hA001, 16'hA002, 16'hA004, 16'hA000};
  logic [7:0]  t_d[6] = '{8'h55, 8'h00, 8'h0B, 8'h40, 8'h77, 8'hAA};
  logic [15:0] t_q[6] = '{16'h0055, 16'h0000, 16'h000B, 16'h0000, 16'h0000, 16'h00AA};
  logic [7:0]  t_cal[3] = '{8'h00, 8'hFF, 8'h7F};

  ots_trim_ctrl dut (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .stop_mode_i(stop), .regulator_level_o(lvl), .coarse_range_o(crs),
    .effective_fine_out_o(eff), .osc_enable_o(osc), .sys_clk_gate_o(gate));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      end_sim();
    end
  end
  // ------------------------------
  // bus tasks
  // ------------------------------
  task automatic wr_t(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    // idle edge so a following write never re-raises wr in the same step
    @(posedge clk);
  endtask : wr_t
  task automatic rd_t(input logic [15:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) q = rdata;
  endtask : rd_t
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  task automatic chk_def();
    `CHK({lvl, crs, eff, osc, gate}, {8'hFF, 2'h1, 8'h8E, 2'h3})
    rd_t(16'hA000);
    `CHK(q, 16'h00FF)
    rd_t(16'hA001);
    `CHK(q, 16'h0001)
  endtask : chk_def
  task automatic sweep(input logic [7:0] f, c, lo, hi);
    wr_t(16'hA001, 8'h00);
    wr_t(16'hA002, f);
    wr_t(16'hA001, c);
    mn = 8'hFF;
    mx = 8'h00;
    repeat (600) begin
      @(posedge clk);
      if (eff < mn) mn = eff;
      if (eff > mx) mx = eff;
    end
    `CHK({mn, mx}, {lo, hi})
  endtask : sweep
  task end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    do_reset();
    chk_def();
    for (i = 0; i < 6; i++) begin
      wr_t(t_a[i], t_d[i]);
      rd_t(t_a[i]);
      `CHK(q, t_q[i])
      if (t_a[i] == 16'hA000) `CHK(lvl, t_d[i])
      if (t_a[i] == 16'hA001) `CHK(crs, t_d[i][1:0])
    end
    wr_t(16'hA002, 8'h33);
    repeat (3) @(posedge clk);
    `CHK(eff, 8'h33)
    rd_t(16'hA003);
    `CHK(q, 16'h0333)
    for (i = 0; i < 4; i++)
      sweep(8'h80, {4'h1, i[1:0], 2'h1}, 8'h80 - (8'h04 << i), 8'h80 + (8'h04 << i));
    sweep(8'h02, 8'h1C, 8'h00, 8'h22);
    sweep(8'hFD, 8'h1C, 8'hDD, 8'hFF);
    wr_t(16'hA001, 8'h00);
    wr_t(16'hA002, 8'h80);
    wr_t(16'hA001, 8'h20);
    pk = 0;
    prev = eff;
    for (j = 0; j < 400 && pk < 2; j++) begin
      @(posedge clk);
      if (eff === 8'h84 && prev !== 8'h84) begin
        tp[pk] = j;
        pk++;
      end
      prev = eff;
    end
    `CHK(tp[1] - tp[0], 72)
    rd_t(16'hA003);
    `CHK(q[10:8], 3'h7)
    stop <= 1'b1;
    for (n = 0; n < 40 && osc !== 1'b0; n++) @(posedge clk);
    `CHK({osc, gate}, 2'h0)
    stop <= 1'b0;
    for (n = 0; n < 40 && osc !== 1'b1; n++) @(posedge clk);
    `CHK({osc, gate}, 2'h2)
    for (n = 0; n < 40 && gate !== 1'b1; n++) @(posedge clk);
    `CHK(gate, 1'b1)
    wr_t(16'hA000, 8'h12);
    wr_t(16'hA001, 8'h1E);
    do_reset();
    chk_def();
    wr_t(16'hA001, 8'h02);
    wr_t(16'hA002, 8'h6C);
    @(posedge clk);
    `CHK({crs, eff}, {2'h2, 8'h6C})
    wr_t(16'hA001, 8'h01);
    for (j = 0; j < 3; j++) begin
      wr_t(16'hA002, t_cal[j]);
      @(posedge clk);
      `CHK({crs, eff}, {2'h1, t_cal[j]})
    end
    end_sim();
  end
endmodule : testbench
